// ===== rtl/touch_probe_map.vh
`ifndef TOUCH_PROBE_MAP_VH
`define TOUCH_PROBE_MAP_VH

// object indices
`define OD_PROBE_CONTROL   16'h60B8
`define OD_PROBE_STATUS    16'h60B9
`define OD_P1_RISE_POS     16'h60BA
`define OD_P1_FALL_POS     16'h60BB
`define OD_P2_RISE_POS     16'h60BC
`define OD_P2_FALL_POS     16'h60BD
`define OD_P1_RISE_CNT     16'h60D5
`define OD_P1_FALL_CNT     16'h60D6
`define OD_P2_RISE_CNT     16'h60D7
`define OD_P2_FALL_CNT     16'h60D8
`define OD_P1_DI_SOURCE    16'h2101
`define OD_P2_DI_SOURCE    16'h2102
`define OD_FILTER_WINDOW   16'h2103

// reset values
`define PROBE_CONTROL_RST  16'h0000
`define DI_SOURCE_RST      3'h4
`define FILTER_WINDOW_RST  16'h0000
`define POS_RST            32'h0000_0000
`define CNT_RST            16'h0000

// writable bits of the control object, reserved bits read zero
`define PROBE_CONTROL_MASK 16'h3737

// control field positions inside one probe's byte
`define CTL_ENABLE         0
`define CTL_CONTINUOUS     1
`define CTL_SRC_INDEX      2
`define CTL_RISE_EN        4
`define CTL_FALL_EN        5

// status field positions inside one probe's byte
`define ST_ENABLED         0
`define ST_RISE_HELD       1
`define ST_FALL_HELD       2

// bit offsets of the two probes' bytes in control and status
`define PROBE1_BASE        0
`define PROBE2_BASE        8

// widths
`define POS_W              32
`define SINGLE_TURN_W      24
`define LINES_W            8

`endif

// ===== rtl/glitch_window_filter.v
`timescale 1ns/1ps
`include "touch_probe_map.vh"

// passes a level only after it has stood window+1 cycles
module glitch_window_filter
(
   // clock and reset
   input  wire        clk,
   input  wire        rstn,
   input  wire        ce,
   // level in and out
   input  wire        level_in,
   input  wire [15:0] window,
   output reg         level_out
);

   reg [15:0] stable_cnt_reg;

   always @(posedge clk)
   begin
      if (!rstn)
      begin
         stable_cnt_reg <= 16'h0000;
         level_out      <= 1'b0;
      end
      else if (ce)
      begin
         if (level_in == level_out)
            stable_cnt_reg <= 16'h0000;
         else if (stable_cnt_reg >= window)
         begin
            level_out      <= level_in;
            stable_cnt_reg <= 16'h0000;
         end
         else
            stable_cnt_reg <= stable_cnt_reg + 16'h0001;
      end
   end

endmodule // glitch_window_filter

// ===== rtl/probe_capture_unit.v
`timescale 1ns/1ps
`include "touch_probe_map.vh"

// one touch probe: edge detect, latch position, count captures
module probe_capture_unit
(
   // clock and reset
   input  wire                clk,
   input  wire                rstn,
   input  wire                ce,
   // control byte of this probe
   input  wire [7:0]          ctrl,
   // trigger levels and position
   input  wire                di_level,
   input  wire                index_level,
   input  wire [`POS_W-1:0]   position,
   // status and captured data
   output wire [7:0]          status,
   output reg  [`POS_W-1:0]   rise_pos_reg,
   output reg  [`POS_W-1:0]   fall_pos_reg,
   output reg  [15:0]         rise_cnt_reg,
   output reg  [15:0]         fall_cnt_reg
);

   reg  trig_prev_reg;
   reg  rise_held_reg;
   reg  fall_held_reg;
   wire enabled;
   wire trig;
   wire rise_edge;
   wire fall_edge;
   wire take_rise;
   wire take_fall;

   assign enabled   = ctrl[`CTL_ENABLE];
   assign trig      = ctrl[`CTL_SRC_INDEX] ? index_level : di_level;
   assign rise_edge = trig & ~trig_prev_reg;
   assign fall_edge = ~trig & trig_prev_reg;
   // single mode takes only the first event of each edge
   assign take_rise = enabled & ctrl[`CTL_RISE_EN] & rise_edge &
                      (ctrl[`CTL_CONTINUOUS] | ~rise_held_reg);
   assign take_fall = enabled & ctrl[`CTL_FALL_EN] & fall_edge &
                      (ctrl[`CTL_CONTINUOUS] | ~fall_held_reg);

   assign status = {5'b00000, fall_held_reg, rise_held_reg, enabled};

   always @(posedge clk)
   begin
      if (!rstn)
      begin
         trig_prev_reg <= 1'b0;
         rise_held_reg <= 1'b0;
         fall_held_reg <= 1'b0;
         rise_pos_reg  <= `POS_RST;
         fall_pos_reg  <= `POS_RST;
         rise_cnt_reg  <= `CNT_RST;
         fall_cnt_reg  <= `CNT_RST;
      end
      else if (ce)
      begin
         trig_prev_reg <= trig;
         if (!enabled)
         begin
            rise_held_reg <= 1'b0;
            fall_held_reg <= 1'b0;
         end
         if (take_rise)
         begin
            rise_pos_reg  <= position;
            rise_cnt_reg  <= rise_cnt_reg + 16'h0001;
            rise_held_reg <= 1'b1;
         end
         if (take_fall)
         begin
            fall_pos_reg  <= position;
            fall_cnt_reg  <= fall_cnt_reg + 16'h0001;
            fall_held_reg <= 1'b1;
         end
      end
   end

endmodule // probe_capture_unit

// ===== rtl/dual_touch_probe_latch.v
// Summary of operation
// - control bit 0 arms probe 1, bit 8 arms probe 2; clearing disarms.
// - bits 1 and 9: 0 captures first event only, 1 every event.
// - bits 2 and 10: 0 digital input line, 1 encoder index pulse.
// - bits 4 and 12 enable capture on the trigger's rising edge.
// - bits 5 and 13 enable capture on the trigger's falling edge.
// - digital input source assignment stays fixed while its probe is enabled.
// - index pulse is made at each single-turn zero point of the encoder.
// - status bits 0 and 8 show probe enabled; status word is cyclic.
// - status bits 1 and 9 set once a rising-edge position is held.
// - status bits 2 and 10 set once a falling-edge position is held.
// - four captured positions read at objects 0x60BA through 0x60BD.
// - rising captures of probe 1 counted and readable at 0x60D5.
// - each enabled edge captures the actual position in reference units.
// - four 16-bit capture counters, one per probe and edge, reset 0.
// - a digital trigger passes a configurable filter window first.
`timescale 1ns/1ps
`include "touch_probe_map.vh"

module dual_touch_probe_latch
(
   // clock and reset
   input  wire                      clk,
   input  wire                      rstn,
   input  wire                      ce,
   // digital input pins, line 4 is the fifth input line
   input  wire [`LINES_W-1:0]       logic_input_line,
   // feedback from the position loop, same clock
   input  wire [`POS_W-1:0]         position_actual,
   input  wire [`SINGLE_TURN_W-1:0] single_turn_pos,
   // object dictionary access
   input  wire [15:0]               od_index,
   input  wire                      od_wr,
   input  wire                      od_rd,
   input  wire [31:0]               od_wdata,
   output reg  [31:0]               od_rdata,
   output reg                       od_ack,
   output reg                       od_err,
   // cyclic status word
   output wire [15:0]               probe_status
);

   reg  [15:0]               probe_control_reg;
   reg  [2:0]                p1_src_reg;
   reg  [2:0]                p2_src_reg;
   reg  [2:0]                p1_src_active_reg;
   reg  [2:0]                p2_src_active_reg;
   reg  [15:0]               filter_window_reg;
   reg  [`LINES_W-1:0]       line_s1_reg;
   reg  [`LINES_W-1:0]       line_s2_reg;
   reg  [`LINES_W-1:0]       line_s3_reg;
   reg  [`LINES_W-1:0]       line_level_reg;
   reg  [`SINGLE_TURN_W-1:0] st_prev_reg;
   reg                       index_reg;
   reg  [31:0]               rdata_next;
   reg                       known_next;
   reg                       writable_next;
   wire [`LINES_W-1:0]       line_differ;
   wire                      p1_di_raw;
   wire                      p2_di_raw;
   wire                      p1_di_filt;
   wire                      p2_di_filt;
   wire [7:0]                p1_status;
   wire [7:0]                p2_status;
   wire [`POS_W-1:0]         p1_rise_pos;
   wire [`POS_W-1:0]         p1_fall_pos;
   wire [`POS_W-1:0]         p2_rise_pos;
   wire [`POS_W-1:0]         p2_fall_pos;
   wire [15:0]               p1_rise_cnt;
   wire [15:0]               p1_fall_cnt;
   wire [15:0]               p2_rise_cnt;
   wire [15:0]               p2_fall_cnt;
   wire                      p1_enabled;
   wire                      p2_enabled;
   wire                      ctl_wr_en;
   wire                      p1_src_wr_en;
   wire                      p2_src_wr_en;
   wire                      window_wr_en;

   assign p1_enabled = probe_control_reg[`PROBE1_BASE + `CTL_ENABLE];
   assign p2_enabled = probe_control_reg[`PROBE2_BASE + `CTL_ENABLE];

   // pin synchroniser: a change counts once stages two and three agree
   assign line_differ = line_s2_reg ^ line_s3_reg;

   always @(posedge clk)
   begin
      if (!rstn)
      begin
         line_s1_reg    <= 8'h00;
         line_s2_reg    <= 8'h00;
         line_s3_reg    <= 8'h00;
         line_level_reg <= 8'h00;
      end
      else if (ce)
      begin
         line_s1_reg    <= logic_input_line;
         line_s2_reg    <= line_s1_reg;
         line_s3_reg    <= line_s2_reg;
         line_level_reg <= (~line_differ & line_s2_reg) |
                           (line_differ & line_level_reg);
      end
   end

   // index pulse stands while the single-turn position sits at zero
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         st_prev_reg <= {`SINGLE_TURN_W{1'b0}};
         index_reg   <= 1'b0;
      end
      else if (ce)
      begin
         st_prev_reg <= single_turn_pos;
         index_reg   <= (single_turn_pos == {`SINGLE_TURN_W{1'b0}}) &
                        (st_prev_reg != {`SINGLE_TURN_W{1'b0}} |
                         index_reg);
      end
   end

   // source assignment follows software only while the probe is off
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         p1_src_active_reg <= `DI_SOURCE_RST;
         p2_src_active_reg <= `DI_SOURCE_RST;
      end
      else if (ce)
      begin
         if (!p1_enabled)
            p1_src_active_reg <= p1_src_reg;
         if (!p2_enabled)
            p2_src_active_reg <= p2_src_reg;
      end
   end

   assign p1_di_raw = line_level_reg[p1_src_active_reg];
   assign p2_di_raw = line_level_reg[p2_src_active_reg];

   glitch_window_filter u_p1_filter
   (
      .clk       (clk),
      .rstn      (rstn),
      .ce        (ce),
      .level_in  (p1_di_raw),
      .window    (filter_window_reg),
      .level_out (p1_di_filt)
   );

   glitch_window_filter u_p2_filter
   (
      .clk       (clk),
      .rstn      (rstn),
      .ce        (ce),
      .level_in  (p2_di_raw),
      .window    (filter_window_reg),
      .level_out (p2_di_filt)
   );

   probe_capture_unit u_probe1
   (
      .clk          (clk),
      .rstn         (rstn),
      .ce           (ce),
      .ctrl         (probe_control_reg[`PROBE1_BASE +: 8]),
      .di_level     (p1_di_filt),
      .index_level  (index_reg),
      .position     (position_actual),
      .status       (p1_status),
      .rise_pos_reg (p1_rise_pos),
      .fall_pos_reg (p1_fall_pos),
      .rise_cnt_reg (p1_rise_cnt),
      .fall_cnt_reg (p1_fall_cnt)
   );

   probe_capture_unit u_probe2
   (
      .clk          (clk),
      .rstn         (rstn),
      .ce           (ce),
      .ctrl         (probe_control_reg[`PROBE2_BASE +: 8]),
      .di_level     (p2_di_filt),
      .index_level  (index_reg),
      .position     (position_actual),
      .status       (p2_status),
      .rise_pos_reg (p2_rise_pos),
      .fall_pos_reg (p2_fall_pos),
      .rise_cnt_reg (p2_rise_cnt),
      .fall_cnt_reg (p2_fall_cnt)
   );

   assign probe_status = {p2_status, p1_status};

   // object read decode
   always @*
   begin
      rdata_next    = 32'h0000_0000;
      known_next    = 1'b1;
      writable_next = 1'b0;
      case (od_index)
         `OD_PROBE_CONTROL:
         begin
            rdata_next    = {16'h0000, probe_control_reg};
            writable_next = 1'b1;
         end
         `OD_PROBE_STATUS: rdata_next = {16'h0000, probe_status};
         `OD_P1_RISE_POS:  rdata_next = p1_rise_pos;
         `OD_P1_FALL_POS:  rdata_next = p1_fall_pos;
         `OD_P2_RISE_POS:  rdata_next = p2_rise_pos;
         `OD_P2_FALL_POS:  rdata_next = p2_fall_pos;
         `OD_P1_RISE_CNT:  rdata_next = {16'h0000, p1_rise_cnt};
         `OD_P1_FALL_CNT:  rdata_next = {16'h0000, p1_fall_cnt};
         `OD_P2_RISE_CNT:  rdata_next = {16'h0000, p2_rise_cnt};
         `OD_P2_FALL_CNT:  rdata_next = {16'h0000, p2_fall_cnt};
         `OD_P1_DI_SOURCE:
         begin
            rdata_next    = {29'h0000_0000, p1_src_reg};
            writable_next = 1'b1;
         end
         `OD_P2_DI_SOURCE:
         begin
            rdata_next    = {29'h0000_0000, p2_src_reg};
            writable_next = 1'b1;
         end
         `OD_FILTER_WINDOW:
         begin
            rdata_next    = {16'h0000, filter_window_reg};
            writable_next = 1'b1;
         end
         default: known_next = 1'b0;
      endcase
   end

   // write strobes, one per writable object
   // a write and a read in one cycle: the read returns the old value
   assign ctl_wr_en    = od_wr & (od_index == `OD_PROBE_CONTROL);
   assign p1_src_wr_en = od_wr & (od_index == `OD_P1_DI_SOURCE);
   assign p2_src_wr_en = od_wr & (od_index == `OD_P2_DI_SOURCE);
   assign window_wr_en = od_wr & (od_index == `OD_FILTER_WINDOW);

   // control object, reserved bits stored as zero
   always @(posedge clk)
   begin
      if (!rstn)
         probe_control_reg <= `PROBE_CONTROL_RST;
      else if (ce & ctl_wr_en)
         probe_control_reg <= od_wdata[15:0] &
                              `PROBE_CONTROL_MASK;
   end

   // trigger line numbers, applied by the source hold logic above
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         p1_src_reg <= `DI_SOURCE_RST;
         p2_src_reg <= `DI_SOURCE_RST;
      end
      else if (ce)
      begin
         if (p1_src_wr_en)
            p1_src_reg <= od_wdata[2:0];
         if (p2_src_wr_en)
            p2_src_reg <= od_wdata[2:0];
      end
   end

   // filter window in clock cycles, shared by both digital triggers
   always @(posedge clk)
   begin
      if (!rstn)
         filter_window_reg <= `FILTER_WINDOW_RST;
      else if (ce & window_wr_en)
         filter_window_reg <= od_wdata[15:0];
   end

   // object access: one-cycle answer, writes to read-only objects refused
   // a read of an unknown index returns zero with the error flag
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         od_rdata <= 32'h0000_0000;
         od_ack   <= 1'b0;
         od_err   <= 1'b0;
      end
      else if (ce)
      begin
         od_ack <= od_wr | od_rd;
         od_err <= (od_wr & ~writable_next) | (od_rd & ~known_next);
         if (od_rd)
            od_rdata <= rdata_next;
      end
   end

endmodule // dual_touch_probe_latch

// ===== tb/probe_latch_checker.sv
`timescale 1ns/1ps
`include "touch_probe_map.vh"

module probe_latch_checker
(
   // clock and reset
   input wire                      clk,
   input wire                      rstn,
   input wire                      ce,
   // pins and feedback
   input wire [`LINES_W-1:0]       logic_input_line,
   input wire [`POS_W-1:0]         position_actual,
   input wire [`SINGLE_TURN_W-1:0] single_turn_pos,
   // object access and status
   input wire [15:0]               od_index,
   input wire                      od_wr,
   input wire                      od_rd,
   input wire [31:0]               od_wdata,
   input wire [31:0]               od_rdata,
   input wire                      od_ack,
   input wire                      od_err,
   input wire [15:0]               probe_status
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   wire req    = ce && (od_wr || od_rd);
   wire idle   = ce && !od_wr && !od_rd;
   wire ctl_wr = ce && od_wr && (od_index == `OD_PROBE_CONTROL);
   wire st_rd  = ce && od_rd && !od_wr && (od_index == `OD_PROBE_STATUS);

   AST_ACK_NEXT: assert property (req |=> od_ack)
      else $error("request not acknowledged next cycle");
   AST_ACK_PULSE: assert property (idle |=> !od_ack)
      else $error("acknowledge without request");
   AST_ERR_WITH_ACK: assert property (od_err |-> od_ack)
      else $error("error flag outside acknowledge");
   AST_ENABLE_WRITE: assert property (ctl_wr |=>
      probe_status[0] == $past(od_wdata[0]) &&
      probe_status[8] == $past(od_wdata[8]))
      else $error("enabled flags do not follow control write");
   AST_RESERVED_ZERO: assert property
      (probe_status[7:3] == 5'h00 && probe_status[15:11] == 5'h00)
      else $error("unused status bits set");
   AST_RISE1_NEEDS_EN: assert property
      ($rose(probe_status[1]) |-> probe_status[0])
      else $error("rise flag set on disabled probe");
   AST_FALL2_NEEDS_EN: assert property
      ($rose(probe_status[10]) |-> probe_status[8])
      else $error("fall flag set on disabled probe");
   AST_CLEAR1: assert property ($fell(probe_status[0]) |->
      ##[0:2] probe_status[2:1] == 2'b00)
      else $error("probe one flags not cleared on disable");
   AST_CLEAR2: assert property ($fell(probe_status[8]) |->
      ##[0:2] probe_status[10:9] == 2'b00)
      else $error("probe two flags not cleared on disable");
   AST_RD_HOLD: assert property (!(ce && od_rd) |=> $stable(od_rdata))
      else $error("read data changed without read");
   AST_RD_STATUS: assert property (st_rd |=>
      od_rdata == {16'h0000, $past(probe_status)})
      else $error("status read differs from status port");

   cover property ($rose(probe_status[1]));
   cover property ($rose(probe_status[10]));
   cover property (od_err);
endmodule // probe_latch_checker

// ===== tb/od_host_model.sv
`timescale 1ns/1ps
`include "touch_probe_map.vh"

module od_host_model
(
   // clock
   input  wire        clk,
   // requests toward the device
   output reg  [15:0] od_index,
   output reg         od_wr,
   output reg         od_rd,
   output reg  [31:0] od_wdata,
   // answers from the device
   input  wire [31:0] od_rdata,
   input  wire        od_ack,
   input  wire        od_err
);
   initial
   begin
      od_index = 16'h0000;
      od_wr    = 1'b0;
      od_rd    = 1'b0;
      od_wdata = 32'h0000_0000;
   end

   // one-cycle request, answer taken at the edge where the ack stands
   task access(input [15:0] idx, input wr, input [31:0] wd,
               output [31:0] rd, output err, output ack);
   begin
      @(posedge clk);
      od_index <= idx;
      od_wr    <= wr;
      od_rd    <= !wr;
      od_wdata <= wd;
      @(posedge clk);
      od_wr    <= 1'b0;
      od_rd    <= 1'b0;
      od_index <= ~idx;
      od_wdata <= ~wd;
      @(posedge clk);
      rd  = od_rdata;
      err = od_err;
      ack = od_ack;
   end
   endtask

   // position is read only after its flag shows a latched value
   task poll(input [15:0] mask, output ok);
      reg [31:0] d;
      reg        e;
      reg        a;
      integer    n;
   begin
      ok = 1'b0;
      for (n = 0; n < 40 && !ok; n = n + 1)
      begin
         access(`OD_PROBE_STATUS, 1'b0, 32'h0000_0000, d, e, a);
         ok = (d[15:0] & mask) != 16'h0000;
      end
   end
   endtask
endmodule // od_host_model

// ===== tb/test_dual_touch_probe_latch.sv
`timescale 1ns/1ps
`include "touch_probe_map.vh"

module test_dual_touch_probe_latch;
   reg                       clk;
   reg                       rstn;
   reg                       ce;
   reg  [`LINES_W-1:0]       lines;
   reg  [`POS_W-1:0]         pos;
   reg  [`SINGLE_TURN_W-1:0] turn;
   wire [15:0]               od_index;
   wire                      od_wr;
   wire                      od_rd;
   wire [31:0]               od_wdata;
   wire [31:0]               od_rdata;
   wire                      od_ack;
   wire                      od_err;
   wire [15:0]               probe_status;
   integer                   n_fail;
   integer                   tests_run;
   integer                   k;
   reg                       ok;

   dual_touch_probe_latch dual_touch_probe_latch_i (.clk(clk), .rstn(rstn),
      .ce(ce), .logic_input_line(lines), .position_actual(pos),
      .single_turn_pos(turn), .od_index(od_index), .od_wr(od_wr),
      .od_rd(od_rd), .od_wdata(od_wdata), .od_rdata(od_rdata),
      .od_ack(od_ack), .od_err(od_err), .probe_status(probe_status));

   od_host_model od_host_model_i (.clk(clk), .od_index(od_index),
      .od_wr(od_wr), .od_rd(od_rd), .od_wdata(od_wdata),
      .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task chk(input [31:0] got, input [31:0] exp);
   begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
         n_fail = n_fail + 1;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask

   task rd(input [15:0] idx, input [31:0] exp, input experr);
      reg [31:0] d;
      reg        e;
      reg        a;
   begin
      od_host_model_i.access(idx, 1'b0, 32'h0000_0000, d, e, a);
      chk(d, exp);
      chk({30'h0000_0000, e, a}, {30'h0000_0000, experr, 1'b1});
   end
   endtask

   task wr(input [15:0] idx, input [31:0] data, input experr);
      reg [31:0] d;
      reg        e;
      reg        a;
   begin
      od_host_model_i.access(idx, 1'b1, data, d, e, a);
      chk({30'h0000_0000, e, a}, {30'h0000_0000, experr, 1'b1});
   end
   endtask

   // trigger held high for w cycles, position steady till both edges land
   task pulse(input [2:0] line, input [31:0] p, input [7:0] w);
   begin
      @(posedge clk);
      pos <= p;
      lines[line] <= 1'b1;
      repeat (w) @(posedge clk);
      lines[line] <= 1'b0;
      repeat (30) @(posedge clk);
   end
   endtask

   task t_objects;
   begin
      rd(`OD_PROBE_CONTROL, 32'h0000_0000, 1'b0);
      rd(`OD_PROBE_STATUS, 32'h0000_0000, 1'b0);
      for (k = 0; k < 4; k = k + 1)
      begin
         rd(16'(`OD_P1_RISE_POS + k), 32'h0000_0000, 1'b0);
         rd(16'(`OD_P1_RISE_CNT + k), 32'h0000_0000, 1'b0);
      end
      wr(`OD_P1_RISE_POS, 32'h0000_0055, 1'b1);
      rd(16'h6000, 32'h0000_0000, 1'b1);
      wr(`OD_PROBE_CONTROL, 32'h0000_FFFF, 1'b0);
      rd(`OD_PROBE_CONTROL, 32'h0000_3737, 1'b0);
      rd(`OD_PROBE_STATUS, 32'h0000_0101, 1'b0);
      wr(`OD_PROBE_CONTROL, 32'h0000_0000, 1'b0);
   end
   endtask

   task t_cont_di;
   begin
      wr(`OD_P1_DI_SOURCE, 32'h0000_0004, 1'b0);
      wr(`OD_FILTER_WINDOW, 32'h0000_0005, 1'b0);
      wr(`OD_PROBE_CONTROL, 32'h0000_0013, 1'b0);
      pulse(3'h4, 32'h0000_1111, 8'h03);
      rd(`OD_PROBE_STATUS, 32'h0000_0001, 1'b0);
      for (k = 1; k < 4; k = k + 1)
      begin
         pulse(3'h4, 32'h0000_1000 + k, 8'h0A);
         od_host_model_i.poll(16'h0002, ok);
         chk({31'h0000_0000, ok}, 32'h0000_0001);
         rd(`OD_P1_RISE_POS, 32'h0000_1000 + k, 1'b0);
         rd(`OD_P1_RISE_CNT, k, 1'b0);
      end
      rd(`OD_PROBE_STATUS, 32'h0000_0003, 1'b0);
      wr(`OD_P1_DI_SOURCE, 32'h0000_0001, 1'b0);
      pulse(3'h1, 32'h0000_2222, 8'h0A);
      rd(`OD_P1_RISE_CNT, 32'h0000_0003, 1'b0);
      pulse(3'h4, 32'h0000_3333, 8'h0A);
      rd(`OD_P1_RISE_POS, 32'h0000_3333, 1'b0);
      wr(`OD_PROBE_CONTROL, 32'h0000_0000, 1'b0);
      rd(`OD_PROBE_STATUS, 32'h0000_0000, 1'b0);
   end
   endtask

   task t_single_p2;
   begin
      wr(`OD_P2_DI_SOURCE, 32'h0000_0002, 1'b0);
      wr(`OD_PROBE_CONTROL, 32'h0000_2100, 1'b0);
      pulse(3'h2, 32'h0000_5555, 8'h0A);
      pulse(3'h2, 32'h0000_6666, 8'h0A);
      rd(`OD_P2_FALL_POS, 32'h0000_5555, 1'b0);
      rd(`OD_P2_FALL_CNT, 32'h0000_0001, 1'b0);
      rd(`OD_P2_RISE_POS, 32'h0000_0000, 1'b0);
      rd(`OD_PROBE_STATUS, 32'h0000_0500, 1'b0);
      wr(`OD_PROBE_CONTROL, 32'h0000_0000, 1'b0);
      rd(`OD_PROBE_STATUS, 32'h0000_0000, 1'b0);
      wr(`OD_PROBE_CONTROL, 32'h0000_2100, 1'b0);
      pulse(3'h2, 32'h0000_7777, 8'h0A);
      rd(`OD_P2_FALL_POS, 32'h0000_7777, 1'b0);
      wr(`OD_PROBE_CONTROL, 32'h0000_0000, 1'b0);
   end
   endtask

   task t_index;
   begin
      wr(`OD_PROBE_CONTROL, 32'h0000_0035, 1'b0);
      @(posedge clk);
      pos <= 32'h0000_8888;
      turn <= 24'h00_0000;
      repeat (10) @(posedge clk);
      pos <= 32'h0000_9999;
      turn <= 24'h00_0100;
      repeat (10) @(posedge clk);
      rd(`OD_P1_RISE_POS, 32'h0000_8888, 1'b0);
      rd(`OD_P1_FALL_POS, 32'h0000_9999, 1'b0);
      rd(`OD_PROBE_STATUS, 32'h0000_0007, 1'b0);
   end
   endtask

   // clock enable low: an index pulse inside the frozen span is not seen
   task t_freeze;
   begin
      wr(`OD_PROBE_CONTROL, 32'h0000_0037, 1'b0);
      @(posedge clk);
      ce <= 1'b0;
      turn <= 24'h00_0000;
      repeat (10) @(posedge clk);
      turn <= 24'h00_0100;
      @(posedge clk);
      ce <= 1'b1;
      repeat (5) @(posedge clk);
      rd(`OD_P1_RISE_CNT, 32'h0000_0005, 1'b0);
      rd(`OD_PROBE_STATUS, 32'h0000_0007, 1'b0);
   end
   endtask

   task report_and_stop;
   begin
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask

   initial
   begin
      repeat (8000) @(posedge clk);
      n_fail = n_fail + 1;
      report_and_stop;
   end

   initial
   begin
      n_fail = 0;
      tests_run = 0;
      rstn = 1'b0;
      ce = 1'b1;
      lines = 8'h00;
      pos = 32'h0000_0000;
      turn = 24'h00_0100;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_objects;
      t_cont_di;
      t_single_p2;
      t_index;
      t_freeze;
      report_and_stop;
   end
endmodule // test_dual_touch_probe_latch

bind dual_touch_probe_latch probe_latch_checker probe_latch_checker_i (
   .clk(clk), .rstn(rstn), .ce(ce), .logic_input_line(logic_input_line),
   .position_actual(position_actual), .single_turn_pos(single_turn_pos),
   .od_index(od_index), .od_wr(od_wr), .od_rd(od_rd),
   .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack),
   .od_err(od_err), .probe_status(probe_status));
